/* File: logic/rac_pkg.sv */
package rac_pkg;
  // Fixed bytes of the answer string
  localparam logic [7:0] ATR_TS = 8'h3B;
  localparam logic [7:0] ATR_T0 = 8'h97;
  localparam logic [7:0] ATR_TA1 = 8'h95;
  localparam logic [7:0] ATR_TD1 = 8'h80;
  localparam logic [7:0] ATR_TD2 = 8'h3F;
  localparam logic [7:0] HIST_CAT = 8'h80;
  localparam logic [7:0] TAG_CDS = 8'h31;
  localparam logic [7:0] TAG_CAP = 8'h73;
  localparam logic [3:0] PROTO_GLOBAL = 4'hF;
  localparam int ATR_LAST = 14;
  // Rate pairs (clock-rate factor, baud divisor)
  localparam int F_DEF = 372;
  localparam int D_DEF = 1;
  localparam int F_FAST = 512;
  localparam int D_MID = 8;
  localparam int D_HIGH = 16;
  localparam logic [8:0] ETU_DEF = 9'(F_DEF / D_DEF);
  localparam logic [8:0] ETU_MID = 9'(F_FAST / D_MID);
  localparam logic [8:0] ETU_HIGH = 9'(F_FAST / D_HIGH);
  typedef enum logic [1:0] {
    RATE_DEF = 2'b00,
    RATE_MID = 2'b01,
    RATE_HIGH = 2'b10,
    RATE_OTHER = 2'b11
  } rac_rate_t;
  // Feature bit positions in the first global tB byte
  localparam int FB_TOP = 7;
  localparam int FB_USB = 6;
  localparam int FB_CLF = 5;
  localparam int FB_LOWZ = 4;
  localparam int FB_SEC = 3;
  localparam int FB_P2P = 2;
  localparam int FB_EMGT = 1;
  localparam int FB_LSI = 0;
  // Terminal register map and reset timing
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_PARM = 4'h8;
  localparam logic [3:0] REG_FEAT = 4'hC;
  localparam int RST_LOW_CYCLES = 400;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  function automatic logic tb_legal(input logic [7:0] b);
    return (b == 8'h00) || (b[FB_TOP] && (b[6:0] != 7'h00) && !(b[FB_P2P] && !b[FB_SEC]));
  endfunction

  function automatic logic [6:0] feat_decode(input logic [7:0] b);
    logic t;
    t = b[FB_TOP];
    return {t & b[FB_LOWZ], t & b[FB_USB], t & b[FB_CLF], t & b[FB_SEC],
            t & b[FB_SEC] & b[FB_P2P], t & b[FB_EMGT], t & b[FB_LSI]};
  endfunction
endpackage

/* File: logic/rac_link_if.sv */
interface rac_link_if;
  logic rst_n;
  logic [1:0] rate_sel;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport card (input rst_n, input rate_sel, output data, output valid, input ready);
  modport term (output rst_n, output rate_sel, input data, input valid, output ready);
endinterface

/* File: logic/rac_card.sv */
module rac_card
  import rac_pkg::*;
#(
  parameter logic [7:0] TA_GLOBAL = 8'h03,
  parameter logic [7:0] TB_GLOBAL = 8'h00,
  parameter logic [7:0] CDS_VALUE = 8'hE0,
  parameter logic [7:0] CAP_1 = 8'h00,
  parameter logic [7:0] CAP_2 = 8'h00,
  parameter logic [7:0] CAP_3 = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link to terminal
  rac_link_if.card lnk,
  // User side status
  output logic atr_busy,
  output logic atr_sent,
  output logic [8:0] etu_cycles,
  output logic [6:0] feat
);

  if (!tb_legal(TB_GLOBAL)) begin : g_bad_tb
    $error("rac_card: global tB coding is reserved");
  end

  typedef enum logic [1:0] {
    G_WAIT = 2'b00,
    G_SEND = 2'b01,
    G_DONE = 2'b10
  } rac_gen_t;

  rac_gen_t st_r, st_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [7:0] xor_r, xor_nxt;
  logic [7:0] byte_cur;
  logic push;
  logic pop;
  logic in_ready;
  logic [7:0] d0_r, d1_r;
  logic v0_r, v1_r;
  logic [8:0] etu_nxt;
  logic [6:0] feat_w;

  always_comb begin
    unique case (idx_r)
      4'd0: byte_cur = ATR_TS;
      4'd1: byte_cur = ATR_T0;
      4'd2: byte_cur = ATR_TA1;
      4'd3: byte_cur = ATR_TD1;
      4'd4: byte_cur = ATR_TD2;
      4'd5: byte_cur = TA_GLOBAL;
      4'd6: byte_cur = TB_GLOBAL;
      4'd7: byte_cur = HIST_CAT;
      4'd8: byte_cur = TAG_CDS;
      4'd9: byte_cur = CDS_VALUE;
      4'd10: byte_cur = TAG_CAP;
      4'd11: byte_cur = CAP_1;
      4'd12: byte_cur = CAP_2;
      4'd13: byte_cur = CAP_3;
      4'd14: byte_cur = xor_r;
      default: byte_cur = 8'h00;
    endcase
  end

  // Generator stalls while the skid entry is full
  assign in_ready = !v1_r;
  assign push = (st_r == G_SEND) && in_ready;
  assign pop = v0_r && lnk.ready;

  // Sequencer restarts on every reset, so warm resets repeat the same string
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    xor_nxt = xor_r;
    unique case (st_r)
      G_WAIT: begin
        idx_nxt = 4'd0;
        xor_nxt = 8'h00;
        st_nxt = G_SEND;
      end
      G_SEND: begin
        if (push) begin
          if (idx_r != 4'd0) begin
            xor_nxt = xor_r ^ byte_cur;
          end
          if (idx_r == 4'(ATR_LAST)) begin
            st_nxt = G_DONE;
          end else begin
            idx_nxt = idx_r + 4'd1;
          end
        end
      end
      G_DONE: begin
        st_nxt = G_DONE;
      end
      default: begin
        st_nxt = G_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn || !lnk.rst_n) begin
      st_r <= G_WAIT;
      idx_r <= 4'd0;
      xor_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      xor_r <= xor_nxt;
    end
  end

  // Two-entry buffer: the skid entry keeps a word when the terminal stalls
  always_ff @(posedge clk) begin
    if (!resetn || !lnk.rst_n) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= 8'h00;
      d1_r <= 8'h00;
    end else if (v1_r) begin
      if (pop) begin
        d0_r <= d1_r;
        v1_r <= 1'b0;
      end
    end else if (push) begin
      if (v0_r && !pop) begin
        d1_r <= byte_cur;
        v1_r <= 1'b1;
      end else begin
        d0_r <= byte_cur;
        v0_r <= 1'b1;
      end
    end else if (pop) begin
      v0_r <= 1'b0;
    end
  end

  // Head entry drives the link straight from flops
  assign lnk.data = d0_r;
  assign lnk.valid = v0_r;

  // Mandatory pairs; unsupported requests keep default
  always_comb begin
    unique case (lnk.rate_sel)
      RATE_MID: etu_nxt = ETU_MID;
      RATE_HIGH: etu_nxt = ETU_HIGH;
      default: etu_nxt = ETU_DEF;
    endcase
  end

  assign feat_w[6] = TB_GLOBAL[FB_TOP] && TB_GLOBAL[FB_LOWZ];
  assign feat_w[5] = TB_GLOBAL[FB_TOP] && TB_GLOBAL[FB_USB];
  assign feat_w[4] = TB_GLOBAL[FB_TOP] && TB_GLOBAL[FB_CLF];
  assign feat_w[3] = TB_GLOBAL[FB_TOP] && TB_GLOBAL[FB_SEC];
  assign feat_w[2] = TB_GLOBAL[FB_TOP] && TB_GLOBAL[FB_SEC] && TB_GLOBAL[FB_P2P];
  assign feat_w[1] = TB_GLOBAL[FB_TOP] && TB_GLOBAL[FB_EMGT];
  assign feat_w[0] = TB_GLOBAL[FB_TOP] && TB_GLOBAL[FB_LSI];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      atr_busy <= 1'b0;
      atr_sent <= 1'b0;
      etu_cycles <= ETU_DEF;
      feat <= 7'h00;
    end else begin
      // Busy until the last byte has left the buffer
      atr_busy <= lnk.rst_n && (st_r != G_DONE || v0_r);
      atr_sent <= lnk.rst_n && st_r == G_DONE && !v0_r;
      // Rate only changes once the generator has queued the last byte
      etu_cycles <= (lnk.rst_n && st_r == G_DONE) ? etu_nxt : ETU_DEF;
      // Capabilities held in flops for the user
      feat <= feat_w;
    end
  end

endmodule

/* File: logic/rac_term.sv */
// Added by the designer: the register addresses and the AHB-Lite slave port.
module rac_term
  import rac_pkg::*;
#(
  parameter int RST_LOW = RST_LOW_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Link to card
  rac_link_if.term lnk
);

  if (RST_LOW < 1 || RST_LOW > 65535) begin : g_bad_rst
    $error("rac_term: reset length out of range");
  end

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_TS = 3'b001,
    P_T0 = 3'b010,
    P_IF = 3'b011,
    P_HIST = 3'b100,
    P_TCK = 3'b101,
    P_DONE = 3'b110
  } rac_parse_t;

  rac_parse_t ps_r;
  logic [15:0] rcnt_r;
  logic rst_n_r, hold_r, pps_r;
  logic [1:0] sel_r;
  logic [3:0] ymask_r, grp_r, hleft_r;
  logic glob_r, tck_need_r, tck_ok_r, ta_f_r, tb_f_r;
  logic [7:0] xor_r, ta1_r, tag_r, tbg_r, h0_r, h1_r, cnt_r;
  logic wr_pend_r;
  logic [3:0] wa_r;
  logic start, acc, take, is_ta, is_tb, is_td, if_end;
  logic map_ok, wr_acc;
  logic rate_ok, hist_ok, tb_rsv;
  logic [3:0] ym_left;
  logic [7:0] b;
  logic [31:0] stat_w, parm_w, rd_w;

  assign acc = hsel && htrans[1] && hready;
  // Unmapped or partial-word writes must not alias onto the control word
  assign map_ok = haddr[31:4] == 28'h0;
  assign wr_acc = acc && hwrite && map_ok && hsize == 3'h2;
  assign start = wr_pend_r && wa_r == REG_CTRL && hwdata[0];
  // Counts the same edges as the card: the registered ready, not its source
  assign take = lnk.valid && lnk.ready;
  assign b = lnk.data;
  assign is_ta = ymask_r[0];
  assign is_tb = !ymask_r[0] && ymask_r[1];
  assign is_td = ymask_r[3:0] == 4'b1000;
  assign ym_left = ymask_r & (ymask_r - 4'd1);
  assign if_end = is_td ? (b[7:4] == 4'h0) : (ym_left == 4'h0);
  assign rate_ok = sel_r != RATE_OTHER || pps_r;
  assign hist_ok = h0_r == HIST_CAT && h1_r == TAG_CDS;
  assign tb_rsv = tb_f_r && !tb_legal(tbg_r);
  assign stat_w = {23'h0, tb_f_r, rate_ok, hist_ok, tb_rsv, tb_f_r, glob_r, tck_ok_r,
                   ps_r == P_DONE, ps_r != P_DONE && ps_r != P_IDLE};
  assign parm_w = {cnt_r, tbg_r, tag_r, ta1_r};
  assign rd_w = haddr[3:0] == REG_CTRL ? {27'h0, pps_r, sel_r, hold_r, 1'b0} :
                haddr[3:0] == REG_STAT ? stat_w :
                haddr[3:0] == REG_PARM ? parm_w :
                haddr[3:0] == REG_FEAT ? {25'h0, feat_decode(tbg_r)} : 32'h0;

  // Bus slave: zero wait states, read data registered in the address phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      wa_r <= 4'h0;
    end else begin
      wr_pend_r <= wr_acc;
      wa_r <= haddr[3:0];
      if (acc && !hwrite) begin
        hrdata <= haddr[31:4] == 28'h0 ? rd_w : 32'h0;
      end
    end
  end

  // Control register and reset contact sequencing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {pps_r, sel_r, hold_r} <= CTRL_RESET[4:1];
      rst_n_r <= 1'b0;
      rcnt_r <= 16'(RST_LOW);
    end else begin
      if (wr_pend_r && wa_r == REG_CTRL) begin
        {pps_r, sel_r, hold_r} <= hwdata[4:1];
      end
      if (start) begin
        rst_n_r <= 1'b0;
        rcnt_r <= 16'(RST_LOW);
      end else if (rcnt_r != 16'h0) begin
        rcnt_r <= rcnt_r - 16'h1;
      end else begin
        rst_n_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lnk.rst_n <= 1'b0;
      lnk.ready <= 1'b0;
      lnk.rate_sel <= RATE_DEF;
    end else begin
      lnk.rst_n <= rst_n_r;
      lnk.ready <= !hold_r && rst_n_r;
      // Only agreed pairs reach the card
      lnk.rate_sel <= rate_ok ? sel_r : RATE_DEF;
    end
  end

  // Parser accepts any protocol type and trailing bytes
  always_ff @(posedge clk) begin
    if (!resetn || start) begin
      ps_r <= start ? P_TS : P_IDLE;
      {ymask_r, grp_r, hleft_r} <= 12'h0;
      {glob_r, tck_need_r, tck_ok_r, ta_f_r, tb_f_r} <= 5'h0;
      {xor_r, ta1_r, tag_r, tbg_r, h0_r, h1_r, cnt_r} <= 56'h0;
    end else if (ps_r == P_IDLE) begin
      // Arms while the reset contact is still low, so no byte is missed
      ps_r <= P_TS;
    end else if (take && ps_r != P_IDLE && ps_r != P_DONE) begin
      cnt_r <= cnt_r + 8'h1;
      xor_r <= ps_r == P_TS ? 8'h00 : xor_r ^ b;
      unique case (ps_r)
        P_TS: ps_r <= P_T0;
        P_T0: begin
          ymask_r <= b[7:4];
          hleft_r <= b[3:0];
          grp_r <= 4'd1;
          ps_r <= b[7:4] != 4'h0 ? P_IF : b[3:0] != 4'h0 ? P_HIST : P_DONE;
        end
        P_IF: begin
          ymask_r <= is_td ? b[7:4] : ym_left;
          if (is_ta && grp_r == 4'd1) begin
            ta1_r <= b;
          end
          if (is_ta && glob_r && !ta_f_r && grp_r > 4'd2) begin
            tag_r <= b;
            ta_f_r <= 1'b1;
          end
          if (is_tb && glob_r && !tb_f_r && grp_r > 4'd2) begin
            tbg_r <= b;
            tb_f_r <= 1'b1;
          end
          if (is_td) begin
            grp_r <= grp_r + 4'd1;
            tck_need_r <= tck_need_r || b[3:0] != 4'h0;
            if (b[3:0] == PROTO_GLOBAL && grp_r > 4'd1) begin
              glob_r <= 1'b1;
            end
          end
          if (if_end) begin
            ps_r <= hleft_r != 4'h0 ? P_HIST :
                    (tck_need_r || (is_td && b[3:0] != 4'h0)) ? P_TCK : P_DONE;
          end
        end
        P_HIST: begin
          hleft_r <= hleft_r - 4'd1;
          if (cnt_r[3:0] == 4'h0 || h0_r == 8'h00 && !hist_ok) begin
            h0_r <= b;
          end
          if (h0_r != 8'h00 && h1_r == 8'h00) begin
            h1_r <= b;
          end
          if (hleft_r == 4'd1) begin
            ps_r <= tck_need_r ? P_TCK : P_DONE;
          end
        end
        P_TCK: begin
          tck_ok_r <= (xor_r ^ b) == 8'h00;
          ps_r <= P_DONE;
        end
        default: ps_r <= P_DONE;
      endcase
    end
  end

endmodule

/* File: bench/rac_link_chk.sv */
module rac_link_chk
  import rac_pkg::*;
#(
  parameter int RST_LOW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link signals
  input wire logic rst_n,
  input wire logic [1:0] rate_sel,
  input wire logic [7:0] data,
  input wire logic valid,
  input wire logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int low_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Counts low time of the reset contact
  always_ff @(posedge clk) begin
    if (!resetn || rst_n)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end
  sequence s_take(logic [7:0] b);
    valid && ready && data == b;
  endsequence
  sequence s_show(logic [7:0] b);
    valid && data == b;
  endsequence
  a_hold_byte: assert property (
    (valid && !ready && rst_n) ##1 rst_n |-> valid && $stable(data))
    else $error("byte dropped during stall");
  a_flush_on_rst: assert property (!rst_n |=> !valid)
    else $error("valid while reset contact low");
  a_first_ts: assert property ($rose(rst_n) ##1 rst_n |=> s_show(ATR_TS))
    else $error("first byte late or wrong");
  a_t0_follows: assert property (s_take(ATR_TS) |-> ##[1:8] s_show(ATR_T0))
    else $error("format byte missing");
  a_hist_cat: assert property (s_take(ATR_TD2) |-> ##[3:8] s_show(HIST_CAT))
    else $error("category byte missing");
  a_cap_order: assert property (s_take(TAG_CDS) |-> ##[2:8] s_show(TAG_CAP))
    else $error("capability tag missing");
  a_ready_off: assert property (!rst_n ##1 !rst_n |-> !ready)
    else $error("ready while reset contact low");
  a_rst_low_len: assert property ($rose(rst_n) |-> low_cnt >= RST_LOW - 1)
    else $error("reset contact pulse too short");
endmodule

/* File: bench/reset_answer_content_bench.sv */
module reset_answer_content_bench
  import rac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic atr_busy;
  logic atr_sent;
  logic [8:0] etu_cycles;
  logic [6:0] feat;
  logic [7:0] got [0:31];
  logic [7:0] exp_b [0:14];
  logic [31:0] rd;
  int fails = 0;
  int n_compared = 0;
  int ng = 0;
  always #25 clk = ~clk;
  rac_link_if lnk ();
  rac_card #(.TB_GLOBAL(8'hAD), .CDS_VALUE(8'hE1), .CAP_1(8'h11)) rac_card_i (.clk(clk),
    .resetn(resetn), .lnk(lnk.card), .atr_busy(atr_busy), .atr_sent(atr_sent),
    .etu_cycles(etu_cycles), .feat(feat));
  // Short reset pulse keeps the run brief
  rac_term #(.RST_LOW(4)) rac_term_i (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lnk(lnk.term));
  rac_link_chk #(.RST_LOW(4)) rac_link_chk_i (.clk(clk), .resetn(resetn),
    .rst_n(lnk.rst_n), .rate_sel(lnk.rate_sel), .data(lnk.data), .valid(lnk.valid),
    .ready(lnk.ready));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("compared=%0d mismatches=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic wait_sent;
    int k;
    k = 0;
    while (atr_sent !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk(atr_sent, 1);
    chk(atr_busy, 0);
  endtask
  task automatic check_string;
    for (int i = 0; i < 15; i++)
      chk(got[i], exp_b[i]);
    chk(ng, 15);
  endtask
  // Captures every byte the terminal takes
  always @(posedge clk) begin
    if (lnk.valid === 1'b1 && lnk.ready === 1'b1) begin
      got[ng[4:0]] <= lnk.data;
      ng <= ng + 1;
    end
  end
  initial begin
    exp_b = '{ATR_TS, ATR_T0, ATR_TA1, ATR_TD1, ATR_TD2, 8'h03, 8'hAD, HIST_CAT, TAG_CDS,
      8'hE1, TAG_CAP, 8'h11, 8'h00, 8'h00, 8'h00};
    for (int i = 1; i < 14; i++)
      exp_b[14] = exp_b[14] ^ exp_b[i];
    repeat (6) @(posedge clk);
    chk(etu_cycles, F_DEF / D_DEF);
    chk(feat, 0);
    resetn <= 1'b1;
    @(posedge clk);
    xfer(1'b0, REG_CTRL, 0);
    chk(rd, CTRL_RESET);
    wait_sent;
    check_string;
    chk(feat, 7'h1D);
    xfer(1'b0, REG_STAT, 0);
    chk(rd & 32'h0000_01FF, 32'h0000_01DE);
    xfer(1'b0, REG_PARM, 0);
    chk(rd, 32'h0FAD_0395);
    xfer(1'b0, REG_FEAT, 0);
    chk(rd, 32'h0000_001D);
    xfer(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h0000_0010, 0);
    chk(rd, 0);
    xfer(1'b0, REG_CTRL, 0);
    chk(rd, 0);
    for (int r = 0; r < 4; r++) begin
      xfer(1'b1, REG_CTRL, 32'(r << 2));
      repeat (3) @(posedge clk);
      chk(etu_cycles, r == 1 ? F_FAST / D_MID : r == 2 ? F_FAST / D_HIGH : F_DEF);
      chk(lnk.rate_sel, r == 3 ? 0 : r);
    end
    xfer(1'b1, REG_CTRL, 32'h0000_001C);
    repeat (3) @(posedge clk);
    chk(lnk.rate_sel, RATE_OTHER);
    chk(etu_cycles, F_DEF);
    // Restart with the terminal stalling
    ng <= 0;
    xfer(1'b1, REG_CTRL, 32'h0000_0003);
    repeat (12) @(posedge clk);
    chk(lnk.valid, 1);
    chk(lnk.data, ATR_TS);
    chk(lnk.ready, 0);
    chk(atr_sent, 0);
    chk(atr_busy, 1);
    xfer(1'b0, REG_STAT, 0);
    chk(rd & 32'h0000_0003, 32'h0000_0001);
    xfer(1'b1, REG_CTRL, 0);
    wait_sent;
    check_string;
    xfer(1'b0, REG_PARM, 0);
    chk(rd, 32'h0FAD_0395);
    final_report;
  end
  // Whole run needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    final_report;
  end
endmodule
